//--- src/tuner_pkg.sv
// Constants, register map and state types of the tuner control block
// Behaviour
// RULE1: LNA switch bit 1 inserts the amplifier
// RULE2: Three-bit detector threshold in baseband control
// RULE3: Manual mode picks one of three oscillators, eight sub-bands
// RULE4: Auto select bit overrides manual oscillator fields
// RULE5: Fractional divider write starts an autotune pass
// RULE6: Host writes all divider registers on retune
// RULE7: Lock shown on status pin and status register
// RULE8: Pump auto bit lets autotuner choose current
// RULE9: Pump auto needs oscillator auto select too
// RULE10: Manual mode uses the single pump-current bit
// RULE11: Each trial waits the two-bit settle delay
// RULE12: Host picks delay longer than PLL settling
// RULE13: Host writes notch 111 when no interferer
// RULE14: ROM entry 1 holds low and high notch codes
// RULE15: ROM entry 2 holds 780 and 470 balun codes
// RULE16: ROM entry 3 holds bandwidth code; 0 reserved
// RULE17: Host writes ROM index before reading entry
// RULE18: Index write copies ROM byte into readback
// RULE19: Host keeps copies of three calibration bytes
// RULE20: Host copies bandwidth code into register 0xA
// RULE21: Host picks notch code by channel frequency
// RULE22: Host interpolates balun code per channel
// RULE23: Serial bus writes auto-increment register address
// RULE24: Readback valid before next register read
package tuner_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] REG_DIV_INT     = 8'h00;
  localparam logic [7:0] REG_DIV_FRAC_HI = 8'h01;
  localparam logic [7:0] REG_DIV_FRAC_LO = 8'h02;
  localparam logic [7:0] REG_TRACK       = 8'h03;
  localparam logic [7:0] REG_LNA         = 8'h04;
  localparam logic [7:0] REG_PLL_CFG     = 8'h05;
  localparam logic [7:0] REG_VCO         = 8'h06;
  localparam logic [7:0] REG_BASEBAND    = 8'h0A;
  localparam logic [7:0] REG_ROM_ADDR    = 8'h0B;
  localparam logic [7:0] REG_STATUS      = 8'h10;
  localparam logic [7:0] REG_ROM_DATA    = 8'h11;
  localparam logic [7:0] REG_TUNE_RB     = 8'h12;
  localparam logic [7:0] RESET_BYTE      = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LNA_SW_BIT    = 0;
  localparam int PUMP_AUTO_BIT = 7;
  localparam int PUMP_MAN_BIT  = 6;
  localparam int DLY_LSB       = 4;
  localparam int VAS_BIT       = 7;
  localparam int OSC_LSB       = 5;
  localparam int SB_LSB        = 2;
  localparam int BW_LSB        = 4;
  localparam int TH_LSB        = 0;
  localparam int NOTCH_LSB     = 4;
  localparam int BAL_LSB       = 0;
  localparam int LOCK_BIT      = 7;
  localparam int RB_OSC_LSB    = 6;
  localparam int RB_SB_LSB     = 3;

  // ****************************************
  // Oscillator ranges and timing
  // ****************************************
  localparam logic [1:0] OSC_LAST = 2'h2;
  localparam logic [2:0] SB_LAST  = 3'h7;
  localparam int CLK_MHZ          = 10;
  localparam int SETTLE_US0       = 50;
  localparam int SETTLE_US1       = 100;
  localparam int SETTLE_US2       = 200;
  localparam int SETTLE_US3       = 400;
  localparam logic [11:0] SETTLE_CYC0 = 12'(SETTLE_US0 * CLK_MHZ);
  localparam logic [11:0] SETTLE_CYC1 = 12'(SETTLE_US1 * CLK_MHZ);
  localparam logic [11:0] SETTLE_CYC2 = 12'(SETTLE_US2 * CLK_MHZ);
  localparam logic [11:0] SETTLE_CYC3 = 12'(SETTLE_US3 * CLK_MHZ);

  // ****************************************
  // Serial bus constants
  // ****************************************
  localparam logic [5:0] DEV_ADDR_BASE = 6'h30;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam logic [3:0] BIT_DONE      = 4'h9;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_DEV  = 3'b001,
    PH_REG  = 3'b011,
    PH_WDAT = 3'b010,
    PH_RDAT = 3'b110
  } bus_phase_type;

  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_WAIT = 2'b01,
    TS_NEXT = 2'b11
  } tune_state_type;

endpackage

//--- src/cal_rom.sv
// Factory calibration ROM with registered read data
`timescale 1ns/1ps
`default_nettype none
module cal_rom #(
  parameter logic [3:0] NOTCH_LOW  = 4'h3,
  parameter logic [3:0] NOTCH_HIGH = 4'hC,
  parameter logic [3:0] BAL_780    = 4'hE,
  parameter logic [3:0] BAL_470    = 4'h2,
  parameter logic [3:0] BB_BW      = 4'h8
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] addr_i,
  output logic      [7:0] data_o
);
  typedef struct packed {
    logic [7:0] data;
  } rom_state_type;

  rom_state_type r;
  rom_state_type next_r;

  // ****************************************
  // Table contents
  // ****************************************
  always_comb begin
    next_r = r;
    unique case (addr_i)
      4'h1:    next_r.data = {NOTCH_LOW, NOTCH_HIGH}; // RULE14
      4'h2:    next_r.data = {BAL_780, BAL_470}; // RULE15
      4'h3:    next_r.data = {BB_BW, 4'h0}; // RULE16
      default: next_r.data = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign data_o = r.data;
endmodule
`default_nettype wire

//--- src/serial_slave.sv
// Two-wire serial register slave with address auto-increment
`timescale 1ns/1ps
`default_nettype none
module serial_slave (
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       addr_sel_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  input  wire logic [7:0] rdata_i
);
  typedef struct packed {
    logic [2:0]                   scl;
    logic [2:0]                   sda;
    logic [1:0]                   sel;
    tuner_pkg::bus_phase_type     ph;
    logic [3:0]                   bitn;
    logic [7:0]                   sh;
    logic                         rw;
    logic                         drive;
    logic [7:0]                   ptr;
    logic [7:0]                   wdata;
    logic                         wr;
  } slave_state_type;

  slave_state_type r;
  slave_state_type next_r;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  always_comb begin
    next_r = r;
    next_r.scl = {r.scl[1:0], scl_i};
    next_r.sda = {r.sda[1:0], sda_i};
    next_r.sel = {r.sel[0], addr_sel_i};
    next_r.wr = 1'b0;
    scl_rise = r.scl[1] & ~r.scl[2];
    scl_fall = ~r.scl[1] & r.scl[2];
    start = r.scl[1] & r.scl[2] & r.sda[2] & ~r.sda[1];
    stop = r.scl[1] & r.scl[2] & ~r.sda[2] & r.sda[1];
    if (start) begin
      next_r.ph = tuner_pkg::PH_DEV;
      next_r.bitn = 4'h0;
      next_r.drive = 1'b0;
    end else if (stop) begin
      next_r.ph = tuner_pkg::PH_IDLE;
      next_r.drive = 1'b0;
    end else if (scl_rise && r.ph != tuner_pkg::PH_IDLE) begin
      if (r.bitn < tuner_pkg::BIT_ACK) begin
        next_r.bitn = r.bitn + 4'h1;
        if (r.ph != tuner_pkg::PH_RDAT) begin
          next_r.sh = {r.sh[6:0], r.sda[1]};
        end
      end else if (r.ph == tuner_pkg::PH_RDAT) begin
        if (r.sda[1]) begin
          next_r.ph = tuner_pkg::PH_IDLE;
        end else begin
          next_r.bitn = tuner_pkg::BIT_DONE;
        end
      end
    end else if (scl_fall && r.ph != tuner_pkg::PH_IDLE) begin
      if (r.ph == tuner_pkg::PH_RDAT && r.bitn < tuner_pkg::BIT_ACK) begin
        next_r.sh = {r.sh[6:0], 1'b0};
        next_r.drive = ~r.sh[6];
      end else if (r.ph == tuner_pkg::PH_RDAT
                   && r.bitn == tuner_pkg::BIT_ACK) begin
        next_r.drive = 1'b0;
      end else if (r.bitn == tuner_pkg::BIT_ACK) begin
        next_r.bitn = tuner_pkg::BIT_DONE;
        next_r.drive = 1'b1;
        unique case (r.ph)
          tuner_pkg::PH_DEV: begin
            next_r.rw = r.sh[0];
            if (r.sh[7:1] != {tuner_pkg::DEV_ADDR_BASE, r.sel[1]}) begin
              next_r.drive = 1'b0;
              next_r.ph = tuner_pkg::PH_IDLE;
            end
          end
          tuner_pkg::PH_REG: next_r.ptr = r.sh;
          default: begin
            next_r.wdata = r.sh;
            next_r.wr = 1'b1;
          end
        endcase
      end else if (r.bitn == tuner_pkg::BIT_DONE) begin
        next_r.bitn = 4'h0;
        next_r.drive = 1'b0;
        if ((r.ph == tuner_pkg::PH_DEV && r.rw)
            || r.ph == tuner_pkg::PH_RDAT) begin
          next_r.ph = tuner_pkg::PH_RDAT;
          next_r.sh = rdata_i;
          next_r.drive = ~rdata_i[7];
          next_r.ptr = r.ptr + 8'h01; // RULE23
        end else if (r.ph == tuner_pkg::PH_DEV) begin
          next_r.ph = tuner_pkg::PH_REG;
        end else if (r.ph == tuner_pkg::PH_REG) begin
          next_r.ph = tuner_pkg::PH_WDAT;
        end else begin
          next_r.ptr = r.ptr + 8'h01; // RULE23
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = r.drive;
  assign reg_addr_o = r.ptr;
  assign wdata_o = r.wdata;
  assign wr_o = r.wr;
endmodule
`default_nettype wire

//--- src/tuner_ctrl.sv
// Tuner control top: register map, autotuner, calibration ROM access
`timescale 1ns/1ps
`default_nettype none
module tuner_ctrl (
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       addr_sel_i,
  input  wire logic       pll_lock_raw_i,
  output logic            status_mux_pin_o,
  output logic            low_noise_amp_switch_o,
  output logic      [2:0] detector_threshold_sel_o,
  output logic      [1:0] oscillator_select_o,
  output logic      [2:0] oscillator_subband_o,
  output logic            pump_current_o,
  output logic      [7:0] divider_int_o,
  output logic     [15:0] divider_frac_o,
  output logic      [3:0] notch_code_o,
  output logic      [3:0] balun_code_o,
  output logic      [3:0] baseband_bandwidth_code_o,
  output logic            autotune_busy_o
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync;
  logic       rstn;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rstn = rst_sync[1];

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                       lock_m;
    logic                       lock_s;
    logic [7:0]                 div_int;
    logic [7:0]                 frac_hi;
    logic [7:0]                 frac_lo;
    logic [7:0]                 track;
    logic [7:0]                 lna;
    logic [7:0]                 pll_cfg;
    logic [7:0]                 vco;
    logic [7:0]                 baseband_control;
    logic [3:0]                 rom_index;
    logic [7:0]                 rom_readback_byte;
    logic [1:0]                 rom_pend;
    tuner_pkg::tune_state_type  ts;
    logic [1:0]                 tune_osc;
    logic [2:0]                 tune_sb;
    logic [11:0]                cnt;
    logic [7:0]                 out_ctl;
    logic [1:0]                 out_osc;
    logic [2:0]                 out_sb;
  } top_state_type;

  top_state_type r;
  top_state_type next_r;

  logic [7:0] reg_addr;
  logic [7:0] wdata;
  logic       wr;
  logic [7:0] rdata;
  logic [7:0] rom_data;
  logic       auto_sel;
  logic       pump_auto;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [11:0] settle_cycles(input logic [1:0] code);
    unique case (code)
      2'h0: settle_cycles = tuner_pkg::SETTLE_CYC0;
      2'h1: settle_cycles = tuner_pkg::SETTLE_CYC1;
      2'h2: settle_cycles = tuner_pkg::SETTLE_CYC2;
      2'h3: settle_cycles = tuner_pkg::SETTLE_CYC3;
    endcase
  endfunction

  function automatic logic wr_hit(input logic we,
                                  input logic [7:0] a,
                                  input logic [7:0] off);
    wr_hit = we && (a == off);
  endfunction

  // ****************************************
  // Submodules
  // ****************************************
  serial_slave u_slave (
    .ref_clk_i  (ref_clk_i),
    .rstn_i     (rstn),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .addr_sel_i (addr_sel_i),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .reg_addr_o (reg_addr),
    .wdata_o    (wdata),
    .wr_o       (wr),
    .rdata_i    (rdata)
  );

  cal_rom u_rom (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn),
    .addr_i    (r.rom_index),
    .data_o    (rom_data)
  );

  // ****************************************
  // Read multiplexer
  // ****************************************
  always_comb begin
    unique case (reg_addr)
      tuner_pkg::REG_DIV_INT:     rdata = r.div_int;
      tuner_pkg::REG_DIV_FRAC_HI: rdata = r.frac_hi;
      tuner_pkg::REG_DIV_FRAC_LO: rdata = r.frac_lo;
      tuner_pkg::REG_TRACK:       rdata = r.track;
      tuner_pkg::REG_LNA:         rdata = r.lna;
      tuner_pkg::REG_PLL_CFG:     rdata = r.pll_cfg;
      tuner_pkg::REG_VCO:         rdata = r.vco;
      tuner_pkg::REG_BASEBAND:    rdata = r.baseband_control;
      tuner_pkg::REG_ROM_ADDR:    rdata = {4'h0, r.rom_index};
      tuner_pkg::REG_STATUS: begin
        rdata = 8'h00;
        rdata[tuner_pkg::LOCK_BIT] = r.lock_s; // RULE7
      end
      tuner_pkg::REG_ROM_DATA:    rdata = r.rom_readback_byte; // RULE18
      tuner_pkg::REG_TUNE_RB: begin
        rdata = 8'h00;
        rdata[tuner_pkg::RB_OSC_LSB +: 2] = r.out_osc;
        rdata[tuner_pkg::RB_SB_LSB +: 3] = r.out_sb;
      end
      default:                    rdata = 8'h00;
    endcase
  end

  // ****************************************
  // Mode decode
  // ****************************************
  assign auto_sel = r.vco[tuner_pkg::VAS_BIT];
  assign pump_auto = r.pll_cfg[tuner_pkg::PUMP_AUTO_BIT] & auto_sel; // RULE9

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r = r;

    // ********************
    // Lock synchroniser
    // ********************
    next_r.lock_m = pll_lock_raw_i;
    next_r.lock_s = r.lock_m;

    // ********************
    // Register writes
    // ********************
    if (wr_hit(wr, reg_addr, tuner_pkg::REG_DIV_INT)) begin
      next_r.div_int = wdata;
    end
    if (wr_hit(wr, reg_addr, tuner_pkg::REG_DIV_FRAC_HI)) begin
      next_r.frac_hi = wdata;
    end
    if (wr_hit(wr, reg_addr, tuner_pkg::REG_DIV_FRAC_LO)) begin
      next_r.frac_lo = wdata;
    end
    if (wr_hit(wr, reg_addr, tuner_pkg::REG_TRACK)) begin
      next_r.track = wdata;
    end
    if (wr_hit(wr, reg_addr, tuner_pkg::REG_LNA)) begin
      next_r.lna = wdata;
    end
    if (wr_hit(wr, reg_addr, tuner_pkg::REG_PLL_CFG)) begin
      next_r.pll_cfg = wdata;
    end
    if (wr_hit(wr, reg_addr, tuner_pkg::REG_VCO)) begin
      next_r.vco = wdata;
    end
    if (wr_hit(wr, reg_addr, tuner_pkg::REG_BASEBAND)) begin
      next_r.baseband_control = wdata;
    end

    // ********************
    // ROM index write and readback copy
    // ********************
    next_r.rom_pend = {r.rom_pend[0], 1'b0};
    if (wr_hit(wr, reg_addr, tuner_pkg::REG_ROM_ADDR)) begin
      next_r.rom_index = wdata[3:0];
      next_r.rom_pend = {r.rom_pend[0], 1'b1};
    end
    if (r.rom_pend[1]) begin
      next_r.rom_readback_byte = rom_data; // RULE18 RULE24
    end

    // ********************
    // Autotuner
    // ********************
    unique case (r.ts)
      tuner_pkg::TS_IDLE: begin
        if (wr_hit(wr, reg_addr, tuner_pkg::REG_DIV_FRAC_LO)
            && auto_sel) begin // RULE5
          next_r.ts = tuner_pkg::TS_WAIT;
          next_r.tune_osc = 2'h0;
          next_r.tune_sb = 3'h0;
          next_r.cnt = settle_cycles(
            r.pll_cfg[tuner_pkg::DLY_LSB +: 2]); // RULE11
        end
      end
      tuner_pkg::TS_WAIT: begin
        if (r.cnt != 12'h000) begin
          next_r.cnt = r.cnt - 12'h001; // RULE11
        end else if (r.lock_s) begin
          next_r.ts = tuner_pkg::TS_IDLE;
        end else begin
          next_r.ts = tuner_pkg::TS_NEXT;
        end
      end
      tuner_pkg::TS_NEXT: begin
        if (r.tune_sb != tuner_pkg::SB_LAST) begin
          next_r.tune_sb = r.tune_sb + 3'h1;
          next_r.ts = tuner_pkg::TS_WAIT;
        end else if (r.tune_osc != tuner_pkg::OSC_LAST) begin
          next_r.tune_osc = r.tune_osc + 2'h1;
          next_r.tune_sb = 3'h0;
          next_r.ts = tuner_pkg::TS_WAIT;
        end else begin
          next_r.ts = tuner_pkg::TS_IDLE;
        end
        next_r.cnt = settle_cycles(r.pll_cfg[tuner_pkg::DLY_LSB +: 2]);
      end
      default: next_r.ts = tuner_pkg::TS_IDLE;
    endcase

    // ********************
    // Oscillator selection
    // ********************
    if (auto_sel) begin
      next_r.out_osc = r.tune_osc; // RULE4
      next_r.out_sb = r.tune_sb; // RULE4
    end else begin
      next_r.out_osc = r.vco[tuner_pkg::OSC_LSB +: 2]; // RULE3
      next_r.out_sb = r.vco[tuner_pkg::SB_LSB +: 3]; // RULE3
    end

    // ********************
    // Registered control outputs
    // ********************
    next_r.out_ctl = 8'h00;
    next_r.out_ctl[0] = r.lna[tuner_pkg::LNA_SW_BIT]; // RULE1
    if (pump_auto) begin
      next_r.out_ctl[1] = ~r.tune_sb[2]; // RULE8
    end else begin
      next_r.out_ctl[1] = r.pll_cfg[tuner_pkg::PUMP_MAN_BIT]; // RULE10
    end
    next_r.out_ctl[2] = r.ts != tuner_pkg::TS_IDLE;
  end

  // ****************************************
  // Register stage
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign status_mux_pin_o = r.lock_s; // RULE7
  assign low_noise_amp_switch_o = r.out_ctl[0];
  assign pump_current_o = r.out_ctl[1];
  assign autotune_busy_o = r.out_ctl[2];
  assign detector_threshold_sel_o =
    r.baseband_control[tuner_pkg::TH_LSB +: 3]; // RULE2
  assign baseband_bandwidth_code_o =
    r.baseband_control[tuner_pkg::BW_LSB +: 4];
  assign oscillator_select_o = r.out_osc;
  assign oscillator_subband_o = r.out_sb;
  assign divider_int_o = r.div_int;
  assign divider_frac_o = {r.frac_hi, r.frac_lo};
  assign notch_code_o = r.track[tuner_pkg::NOTCH_LSB +: 4];
  assign balun_code_o = r.track[tuner_pkg::BAL_LSB +: 4];

endmodule
`default_nettype wire

//--- dv/tuner_ctrl_assertions.sv
// Port checker for the tuner control block
`timescale 1ns/1ps
`default_nettype none
module tuner_ctrl_assertions (
  input wire logic       ref_clk_i,
  input wire logic       rstn_i,
  input wire logic       scl_i,
  input wire logic       sda_oe_o,
  input wire logic       pll_lock_raw_i,
  input wire logic       status_mux_pin_o,
  input wire logic       low_noise_amp_switch_o,
  input wire logic [2:0] detector_threshold_sel_o,
  input wire logic [1:0] oscillator_select_o,
  input wire logic [2:0] oscillator_subband_o,
  input wire logic       pump_current_o,
  input wire logic [3:0] notch_code_o,
  input wire logic       autotune_busy_o
);
  logic [16:0] run_cnt;
  logic  [4:0] osb;
  assign osb = {oscillator_select_o, oscillator_subband_o};
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
      run_cnt <= 17'h00000;
    else
      run_cnt <= autotune_busy_o ? run_cnt + 17'h00001 : 17'h00000;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // ******
  // Checks
  // ******
  lock_on_a: assert property (
    pll_lock_raw_i [*8] |=> status_mux_pin_o)
    else $error("lock not shown on pin");
  lock_off_a: assert property (
    !pll_lock_raw_i [*8] |=> !status_mux_pin_o)
    else $error("pin shows lock while unlocked");
  settle_wait_a: assert property (
    $fell(autotune_busy_o) |-> $past(run_cnt) >= 17'(tuner_pkg::SETTLE_CYC0))
    else $error("autotune trial shorter than settle time");
  tune_step_a: assert property (
    autotune_busy_o && $past(autotune_busy_o) && $changed(osb)
    |-> osb == $past(osb) + 5'h01 || osb == 5'h00)
    else $error("autotune skipped a setting");
  reg_write_a: assert property (
    $changed({low_noise_amp_switch_o, detector_threshold_sel_o,
              notch_code_o}) |-> sda_oe_o)
    else $error("control output moved without a write");
  pump_cause_a: assert property (
    $changed(pump_current_o) |-> sda_oe_o || autotune_busy_o
    || $past(autotune_busy_o) || $past(autotune_busy_o, 2))
    else $error("pump current moved without cause");
  busy_start_a: assert property (
    $rose(autotune_busy_o) |-> ##[0:4] sda_oe_o)
    else $error("autotune started without a write");
  sda_edge_a: assert property (
    $changed(sda_oe_o) |-> !scl_i)
    else $error("data line moved while clock high");
  cover property ($fell(autotune_busy_o));
  cover property ($rose(status_mux_pin_o));
  cover property ($rose(sda_oe_o));
endmodule
bind tuner_ctrl tuner_ctrl_assertions chk (
  .ref_clk_i, .rstn_i, .scl_i, .sda_oe_o, .pll_lock_raw_i,
  .status_mux_pin_o, .low_noise_amp_switch_o, .detector_threshold_sel_o,
  .oscillator_select_o, .oscillator_subband_o, .pump_current_o,
  .notch_code_o, .autotune_busy_o
);
`default_nettype wire

//--- dv/serial_host.sv
// Two-wire bus master model standing in for the host
`timescale 1ns/1ps
`default_nettype none
module serial_host #(
  parameter int Q = 8
) (
  input  wire logic       clk_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            pull_o,
  output logic            done_o,
  output logic      [7:0] byte_o
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
    done_o = 1'b0;
    byte_o = 8'h00;
  end
  // ******
  // Frames
  // ******
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic start();
    pull_o = 1'b0;
    wt(Q);
    scl_o = 1'b1;
    wt(Q);
    pull_o = 1'b1;
    wt(Q);
    scl_o = 1'b0;
    wt(Q);
  endtask
  task automatic stop();
    pull_o = 1'b1;
    wt(Q);
    scl_o = 1'b1;
    wt(Q);
    pull_o = 1'b0;
    wt(Q);
  endtask
  task automatic bit_io(input logic b, output logic r);
    pull_o = !b;
    wt(Q);
    scl_o = 1'b1;
    wt(Q);
    r = sda_i;
    wt(Q);
    scl_o = 1'b0;
    wt(Q);
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic rx();
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, byte_o[i]);
    bit_io(1'b1, r);
    done_o = 1'b1;
    wt(1);
    done_o = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- dv/tuner_autotune_rom_access_tb_top.sv
// Self-checking bench for the tuner control block
`timescale 1ns/1ps
`default_nettype none
module tuner_autotune_rom_access_tb_top;
  localparam logic [7:0] DW = 8'hC2;
  localparam logic [15:0] ROMX [4] = '{16'h0000, 16'hFF3C, 16'hFFE2,
                                       16'hF080};
  logic        clk, rstn, lock, scl, pull, hd, pin, lna, pc, busy, oe, so;
  logic        k, ok;
  logic  [7:0] hb, di, rv, m;
  logic  [2:0] th, sb;
  logic  [1:0] osc;
  logic [15:0] df;
  logic  [3:0] nt, bl, bw;
  logic [15:0] eq[$];
  int          seed, blen, cyc, mismatches, num_checks;
  wire logic   sda;
  assign sda = !pull && (oe ? so : 1'b1);
  tuner_ctrl DUT (
    .ref_clk_i(clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda),
    .sda_o(so), .sda_oe_o(oe), .addr_sel_i(1'b1), .pll_lock_raw_i(lock),
    .status_mux_pin_o(pin), .low_noise_amp_switch_o(lna),
    .detector_threshold_sel_o(th), .oscillator_select_o(osc),
    .oscillator_subband_o(sb), .pump_current_o(pc), .divider_int_o(di),
    .divider_frac_o(df), .notch_code_o(nt), .balun_code_o(bl),
    .baseband_bandwidth_code_o(bw), .autotune_busy_o(busy)
  );
  serial_host #(.Q(8)) h (
    .clk_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull),
    .done_o(hd), .byte_o(hb)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (busy === 1'b1)
      blen++;
    if (cyc == 90000) begin
      mismatches++;
      final_report();
    end
  end
  always @(posedge hd) begin
    m = eq[0][15:8];
    cmp({8'h00, hb & m}, eq[0] & {8'h00, m});
    void'(eq.pop_front());
  end
  // *****
  // Tasks
  // *****
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic put(input logic [7:0] d);
    h.tx(d, k);
    cmp({15'h0000, k}, 16'h0000);
  endtask
  task automatic w1(input logic [7:0] a, input logic [7:0] d);
    h.start();
    put(DW);
    put(a);
    put(d);
    h.stop();
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    eq.push_back(e);
    h.start();
    put(DW);
    put(a);
    h.start();
    put(DW | 8'h01);
    h.rx();
    h.stop();
  endtask
  task automatic tune(input logic [7:0] cfg);
    w1(8'h05, cfg);
    blen = 0;
    w1(8'h02, 8'h00);
    repeat (14000)
      if (busy === 1'b1)
        wt(1);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    seed = 35;
    rstn = 1'b0;
    lock = 1'b0;
    wt(2);
    rstn = 1'b1;
    wt(6);
    w1(8'h06, 8'h34);
    cmp({11'h000, osc, sb}, 16'h000D);
    w1(8'h04, 8'h01);
    cmp({15'h0000, lna}, 16'h0001);
    w1(8'h04, 8'h00);
    cmp({15'h0000, lna}, 16'h0000);
    rv = {5'h10, 3'($random(seed))};
    w1(8'h0A, rv);
    cmp({8'h00, bw, 1'b0, th}, {8'h00, rv});
    rd(8'h0A, {8'hFF, rv});
    w1(8'h03, 8'h78);
    cmp({8'h00, nt, bl}, 16'h0078);
    h.start();
    put(DW);
    put(8'h00);
    put(8'h0E);
    put(8'hD8);
    put(8'hE1);
    h.stop();
    cmp({8'h00, di}, 16'h000E);
    cmp(df, 16'hD8E1);
    cmp({15'h0000, busy}, 16'h0000);
    w1(8'h05, 8'h40);
    cmp({15'h0000, pc}, 16'h0001);
    w1(8'h05, 8'h80);
    cmp({15'h0000, pc}, 16'h0000);
    w1(8'h06, 8'h80);
    lock = 1'b1;
    for (int c = 0; c < 4; c++) begin
      tune(8'hC0 | 8'(c * 16));
      ok = blen >= (500 << c) && blen <= (500 << c) + 8;
      cmp({15'h0000, ok}, 16'h0001);
    end
    cmp({10'h000, osc, sb, pc}, 16'h0001);
    rd(8'h12, 16'hF800);
    rd(8'h10, 16'h8080);
    cmp({15'h0000, pin}, 16'h0001);
    lock = 1'b0;
    tune(8'hC0);
    cmp({10'h000, osc, sb, pc}, 16'h002E);
    w1(8'h12, 8'hFF);
    rd(8'h12, 16'hF8B8);
    rd(8'h10, 16'h8000);
    cmp({15'h0000, pin}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      w1(8'h0B, 8'(i));
      rd(8'h11, ROMX[i]);
    end
    w1(8'h03, {ROMX[1][7:4], 4'h8});
    cmp({12'h000, nt}, {12'h000, ROMX[1][7:4]});
    rd(8'h20, 16'hFF00);
    h.start();
    h.tx(DW ^ 8'h02, k);
    h.stop();
    cmp({15'h0000, k}, 16'h0001);
    wt(20);
    final_report();
  end
endmodule
`default_nettype wire
